/* File: core/cpr_defs.svh */
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH

// Opcode encodings
`define CPR_OP_PUSH 16'h0005
`define CPR_OP_SWRESET 16'h00ff
`define CPR_RELATIVE_CALL_TOP 5'h1b
`define CPR_RELATIVE_CALL_HI 15
`define CPR_RELATIVE_CALL_LO 11
`define CPR_OFS_W 11

// Return address step in bytes (one program word)
`define CPR_PC_STEP 21'h000002

// Reset values
`define CPR_PC_RST 21'h000000
`define CPR_TOS_RST 21'h000000
`define CPR_SP_RST 5'h00

// Clock and software reset pulse length
`define CPR_CLK_PERIOD_NS 5
`define CPR_SWRST_NS 20
`define CPR_SWRST_CYC ((`CPR_SWRST_NS + `CPR_CLK_PERIOD_NS - 1) / `CPR_CLK_PERIOD_NS)

`endif

/* File: core/cpr_pkg.sv */
package cpr_pkg;
    typedef enum logic [1:0] {
        CPR_Q1 = 2'b00,
        CPR_Q2 = 2'b01,
        CPR_Q3 = 2'b10,
        CPR_Q4 = 2'b11
    } cpr_quarter_e;

    typedef enum logic [1:0] {
        CPR_ST_DECODE = 2'b00,
        CPR_ST_PUSH = 2'b01,
        CPR_ST_CALL = 2'b10,
        CPR_ST_CALL_NOP = 2'b11
    } cpr_state_e;
endpackage

/* File: core/cpr_stack_mem.sv */
`timescale 1ns/1ps
// Return stack storage; read data registered
module cpr_stack_mem #(
    parameter int AW = 5,
    parameter int DW = 21
) (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // No reset: contents are only meaningful below the stack pointer
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

/* File: core/cpr_exec.sv */
`timescale 1ns/1ps
`include "cpr_defs.svh"

// The RST_CYC default below uses the shared timing macros
module cpr_exec #(
    parameter int PC_W = 21,
    parameter int SP_W = 5,
    parameter int RST_CYC = `CPR_SWRST_CYC
) (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic i_ce,
    input wire logic [1:0] i_quarter,
    input wire logic i_insn_valid,
    input wire logic [15:0] i_insn,
    input wire logic [PC_W-1:0] i_program_counter,
    output logic [PC_W-1:0] o_program_counter,
    output logic o_pc_write,
    output logic [PC_W-1:0] o_return_stack_top,
    output logic [PC_W-1:0] o_return_stack_below,
    output logic [SP_W-1:0] o_stack_depth,
    output logic o_busy,
    output logic o_flags_write,
    output logic o_reset_request
);

    cpr_pkg::cpr_state_e state_q, state_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic pc_wr_q, pc_wr_d;
    logic [PC_W-1:0] tos_q, tos_d;
    logic [PC_W-1:0] ret_q, ret_d;
    logic [PC_W-1:0] tgt_q, tgt_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic [10:0] ofs_q, ofs_d;
    logic rst_q, rst_d;
    logic [7:0] rst_cnt_q, rst_cnt_d;
    logic busy_q, busy_d;
    logic flags_wr_q, flags_wr_d;
    logic swrst_mark;
    logic [SP_W-1:0] below_addr;
    logic mem_we;
    logic [PC_W-1:0] below;
    logic is_push, is_call, is_swrst;
    logic [PC_W-1:0] ofs_ext;

    // Opcode decode; only sampled in phase one of a new instruction
    assign is_push = (i_insn == `CPR_OP_PUSH);
    assign is_call = (i_insn[`CPR_RELATIVE_CALL_HI:`CPR_RELATIVE_CALL_LO]
                      == `CPR_RELATIVE_CALL_TOP);
    assign is_swrst = (i_insn == `CPR_OP_SWRESET);
    // Sign extension of the word offset, then doubled to bytes
    assign ofs_ext = {{(PC_W-11){ofs_q[10]}}, ofs_q};

    // Marker left by the decoder: this pass is a software reset
    assign swrst_mark = (ofs_q == 11'h7ff);
    // Slot below the top: old top is spilled there on each push
    assign mem_we = i_ce && (i_quarter == cpr_pkg::CPR_Q2) &&
                    ((state_q == cpr_pkg::CPR_ST_PUSH && !swrst_mark) ||
                     state_q == cpr_pkg::CPR_ST_CALL);
    // Read one slot under the pointer, where the last spill went
    assign below_addr = sp_q - SP_W'(1);

    cpr_stack_mem #(
        .AW(SP_W),
        .DW(PC_W)
    ) u_stack (
        .i_clk(I_CLOCK),
        .i_ce(i_ce),
        .i_we(mem_we),
        .i_waddr(sp_q),
        .i_wdata(tos_q),
        .i_raddr(below_addr),
        .o_rdata(below)
    );

    // Sequencer and datapath next values
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        pc_wr_d = 1'b0;
        tos_d = tos_q;
        ret_d = ret_q;
        tgt_d = tgt_q;
        sp_d = sp_q;
        ofs_d = ofs_q;
        rst_d = rst_q;
        rst_cnt_d = rst_cnt_q;
        busy_d = busy_q;
        // Never raised: the status flags belong to other instructions
        flags_wr_d = 1'b0;
        // Reset request held a fixed width so every block sees it
        if (rst_cnt_q != 8'h00) begin
            rst_cnt_d = rst_cnt_q - 8'h01;
            rst_d = (rst_cnt_q != 8'h01);
        end
        case (state_q)
            cpr_pkg::CPR_ST_DECODE: begin
                if (i_insn_valid && i_quarter == cpr_pkg::CPR_Q1) begin
                    ret_d = i_program_counter + PC_W'(`CPR_PC_STEP);
                    ofs_d = i_insn[`CPR_OFS_W-1:0];
                    if (is_push) begin
                        state_d = cpr_pkg::CPR_ST_PUSH;
                        busy_d = 1'b1;
                    end else if (is_call) begin
                        state_d = cpr_pkg::CPR_ST_CALL;
                        busy_d = 1'b1;
                    end else if (is_swrst) begin
                        state_d = cpr_pkg::CPR_ST_PUSH;
                        busy_d = 1'b1;
                        ofs_d = 11'h7ff; // Marks reset, not a push
                    end
                end
            end
            cpr_pkg::CPR_ST_PUSH: begin
                if (i_quarter == cpr_pkg::CPR_Q2) begin
                    // Opcode bus may have moved on; trust the marker
                    if (swrst_mark) begin
                        rst_d = 1'b1;
                        rst_cnt_d = 8'(RST_CYC);
                    end else begin
                        tos_d = ret_q;
                        sp_d = sp_q + SP_W'(1);
                    end
                end
                // Phases three and four idle; done after phase four
                if (i_quarter == cpr_pkg::CPR_Q4) begin
                    state_d = cpr_pkg::CPR_ST_DECODE;
                    busy_d = 1'b0;
                end
            end
            cpr_pkg::CPR_ST_CALL: begin
                case (i_quarter)
                    cpr_pkg::CPR_Q2: begin
                        tos_d = ret_q;
                        sp_d = sp_q + SP_W'(1);
                    end
                    cpr_pkg::CPR_Q3: begin
                        tgt_d = ret_q + PC_W'(ofs_ext << 1);
                    end
                    cpr_pkg::CPR_Q4: begin
                        pc_d = tgt_q;
                        pc_wr_d = 1'b1;
                        state_d = cpr_pkg::CPR_ST_CALL_NOP;
                    end
                    default: begin
                    end
                endcase
            end
            cpr_pkg::CPR_ST_CALL_NOP: begin
                // Whole second cycle idle while fetch refills
                if (i_quarter == cpr_pkg::CPR_Q4) begin
                    state_d = cpr_pkg::CPR_ST_DECODE;
                    busy_d = 1'b0;
                end
            end
            default: begin
                state_d = cpr_pkg::CPR_ST_DECODE;
            end
        endcase
    end

    // State registers; clock enable freezes everything
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_q <= cpr_pkg::CPR_ST_DECODE;
            pc_q <= `CPR_PC_RST;
            pc_wr_q <= 1'b0;
            tos_q <= `CPR_TOS_RST;
            ret_q <= `CPR_PC_RST;
            tgt_q <= `CPR_PC_RST;
            sp_q <= `CPR_SP_RST;
            ofs_q <= 11'h000;
            rst_q <= 1'b0;
            rst_cnt_q <= 8'h00;
            busy_q <= 1'b0;
            flags_wr_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            pc_q <= pc_d;
            pc_wr_q <= pc_wr_d;
            tos_q <= tos_d;
            ret_q <= ret_d;
            tgt_q <= tgt_d;
            sp_q <= sp_d;
            ofs_q <= ofs_d;
            rst_q <= rst_d;
            rst_cnt_q <= rst_cnt_d;
            busy_q <= busy_d;
            flags_wr_q <= flags_wr_d;
        end
    end

    // Below-top value captured from registered memory read
    logic [PC_W-1:0] below_q;
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            below_q <= `CPR_TOS_RST;
        end else if (i_ce) begin
            below_q <= below;
        end
    end

    assign o_program_counter = pc_q;
    assign o_pc_write = pc_wr_q;
    assign o_return_stack_top = tos_q;
    assign o_return_stack_below = below_q;
    assign o_stack_depth = sp_q;
    assign o_busy = busy_q;
    // Status flags never written; kept flop-driven like every output
    assign o_flags_write = flags_wr_q;
    assign o_reset_request = rst_q;
endmodule

/* File: verification/cpr_exec_sva.sv */
`timescale 1ns/1ps
// Watches the executor ports only; pc, top, depth and call target are latched at decode
module cpr_exec_sva #(
    parameter int PC_W = 21,
    parameter int SP_W = 5,
    parameter int RST_CYC = 4
) (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic i_ce,
    input wire logic [1:0] i_quarter,
    input wire logic i_insn_valid,
    input wire logic [15:0] i_insn,
    input wire logic [PC_W-1:0] i_program_counter,
    input wire logic [PC_W-1:0] o_program_counter,
    input wire logic o_pc_write,
    input wire logic [PC_W-1:0] o_return_stack_top,
    input wire logic [PC_W-1:0] o_return_stack_below,
    input wire logic [SP_W-1:0] o_stack_depth,
    input wire logic o_busy,
    input wire logic o_flags_write,
    input wire logic o_reset_request
);
    logic acc, acc_push, acc_call, acc_rst;
    logic [PC_W-1:0] pc_q, top_q, tgt_q;
    logic [SP_W-1:0] dep_q;
    int cnt_q;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // Decode accepted only in phase one while idle
    assign acc = i_ce && i_quarter == 2'h0 && i_insn_valid && !o_busy;
    assign acc_push = acc && i_insn == 16'h0005;
    assign acc_call = acc && i_insn[15:11] == 5'h1b;
    assign acc_rst = acc && i_insn == 16'h00ff;
    // Snapshot at decode, stable because decodes are at least four phases apart
    always_ff @(posedge I_CLOCK) begin
        if (acc) begin
            pc_q <= i_program_counter;
            top_q <= o_return_stack_top;
            dep_q <= o_stack_depth;
            tgt_q <= i_program_counter + PC_W'(2)
                + {{(PC_W-12){i_insn[10]}}, i_insn[10:0], 1'b0};
        end
    end
    // Length of the current reset request
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) cnt_q <= 0;
        else cnt_q <= o_reset_request ? cnt_q + 1 : 0;
    end
    chk_flags_untouched: assert property (!o_flags_write)
        else $error("flag write seen");
    chk_pcw_single: assert property (o_pc_write |=> !o_pc_write)
        else $error("pc write longer than one cycle");
    chk_push_top: assert property (acc_push |-> ##[1:2]
        o_return_stack_top == pc_q + PC_W'(2)) else $error("push top wrong");
    chk_push_below: assert property (acc_push |-> ##[1:4]
        o_return_stack_below == top_q) else $error("old top not below");
    chk_push_depth: assert property (acc_push |-> ##[1:2]
        o_stack_depth == SP_W'(dep_q + 1)) else $error("depth not bumped");
    chk_call_target: assert property (acc_call |-> ##[3:4]
        (o_pc_write && o_program_counter == tgt_q))
        else $error("call target wrong");
    chk_call_order: assert property (acc_call |=> !o_pc_write[*2])
        else $error("pc written before push");
    chk_call_busy: assert property (acc_call |=> o_busy[*6])
        else $error("call second cycle not held");
    chk_rst_start: assert property (acc_rst |-> ##[1:2] o_reset_request)
        else $error("reset request late");
    chk_rst_length: assert property ($fell(o_reset_request)
        |-> cnt_q == RST_CYC) else $error("reset request length wrong");
    cov_push: cover property (acc_push);
    cov_call: cover property (acc_call);
    cov_rst: cover property (acc_rst);
endmodule
bind cpr_exec cpr_exec_sva #(.PC_W(PC_W), .SP_W(SP_W), .RST_CYC(RST_CYC))
    u_sva (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_ce(i_ce),
    .i_quarter(i_quarter), .i_insn_valid(i_insn_valid), .i_insn(i_insn),
    .i_program_counter(i_program_counter),
    .o_program_counter(o_program_counter), .o_pc_write(o_pc_write),
    .o_return_stack_top(o_return_stack_top),
    .o_return_stack_below(o_return_stack_below),
    .o_stack_depth(o_stack_depth), .o_busy(o_busy),
    .o_flags_write(o_flags_write), .o_reset_request(o_reset_request));

/* File: verification/cpr_exec_bench.sv */
`timescale 1ns/1ps
module cpr_exec_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic vld = 1'b0;
    logic [1:0] qtr = 2'h0;
    logic [15:0] insn = 16'h0000;
    logic [20:0] pc = 21'h000000;
    logic [20:0] npc, top, below, pc_seen;
    logic [4:0] dep;
    logic pcw, busy, fw, rreq;
    logic [10:0] offs [3] = '{11'h3ff, 11'h400, 11'h000};
    int rst_len, busy_len;
    int error_cnt = 0;
    int n_checks = 0;
    // 200 MHz
    always #2.5 clk = ~clk;
    cpr_exec dut (.I_CLOCK(clk), .I_RST(rst), .i_ce(ce), .i_quarter(qtr),
        .i_insn_valid(vld), .i_insn(insn), .i_program_counter(pc),
        .o_program_counter(npc), .o_pc_write(pcw),
        .o_return_stack_top(top), .o_return_stack_below(below),
        .o_stack_depth(dep), .o_busy(busy), .o_flags_write(fw),
        .o_reset_request(rreq));
    task automatic check(input string what, input logic [20:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One instruction plus an idle cycle; outputs sampled mid-cycle
    task automatic run(input logic [15:0] op, input logic [20:0] at,
        input int cyc);
        pc_seen = 21'h1fffff;
        rst_len = 0;
        busy_len = 0;
        for (int i = 0; i < (cyc + 1) * 4; i++) begin
            @(negedge clk);
            if (pcw === 1'b1) pc_seen = npc;
            if (rreq === 1'b1) rst_len++;
            if (busy === 1'b1) busy_len++;
            qtr = 2'(i);
            vld = (i == 0);
            insn = op;
            pc = at;
        end
    endtask
    task automatic t_push();
        run(16'h0005, 21'h000100, 1);
        run(16'h0005, 21'h000124, 1);
        check("top", top, 21'h000126);
        check("below", below, 21'h000102);
        check("depth", 21'(dep), 21'h000002);
        check("no pc write", pc_seen, 21'h1fffff);
        check("push busy", 21'(busy_len), 21'h000003);
    endtask
    // Both offset extremes and zero
    task automatic t_call();
        for (int k = 0; k < 3; k++) begin
            run({5'h1b, offs[k]}, 21'h001000, 2);
            check("call top", top, 21'h001002);
            check("target", pc_seen, 21'h001002
                + {{9{offs[k][10]}}, offs[k], 1'b0});
            check("flags", 21'(fw), 21'h000000);
            check("call busy", 21'(busy_len), 21'h000007);
        end
        check("call depth", 21'(dep), 21'h000005);
    endtask
    // Neighbouring encodings must do nothing
    task automatic t_ignore();
        run(16'hd000, 21'h000200, 1);
        run(16'h0006, 21'h000200, 1);
        check("idle depth", 21'(dep), 21'h000005);
        check("idle pc", pc_seen, 21'h1fffff);
    endtask
    // Clock enable low: a push must leave no trace
    task automatic t_freeze();
        ce = 1'b0;
        run(16'h0005, 21'h000300, 1);
        check("frozen busy", 21'(busy_len), 21'h000000);
        check("frozen depth", 21'(dep), 21'h000005);
        check("frozen top", top, 21'h001002);
        ce = 1'b1;
    endtask
    task automatic t_reset();
        run(16'h00ff, 21'h000010, 2);
        check("reset len", 21'(rst_len), 21'h000004);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check("reset top", top, 21'h000000);
        check("reset depth", 21'(dep), 21'h000000);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_push();
        t_call();
        t_ignore();
        t_freeze();
        t_reset();
        test_done();
    end
endmodule
